//--- inc/pdwt_pkg.sv
// What this block does
// - Accept any address inside enabled window
// - Only window 3 decodes dual-address cycles
// - DAC hit needs high zero, base match
// - Hit translates to 33-bit memory address
// - Direct map ORs masked base, address
// - Physical bits 39..33 always zero
// - Table select walks page table in memory
// - Entry address joins base and address
// - Entry: valid bit 0, page bits 20..1
// - Page address above address bits 12..2
// - Eight-entry associative buffer skips fetches
// - Four lockable entries; locked ones never replaced
// - Tag bits 31..15, four pages each
// - Hit needs tag, dual flag, valid
// - Miss fetches four, round-robin unlocked victim
// - Refill loads tag and dual flag
// - Invalid entry raises exception
// - Invalidate-all clears every buffer entry
// - Mask sets power-of-two window size
// - Disabled window never hits
// - Hit claims cycle with device select
package pdwt_pkg;
  localparam int PDWT_WINDOWS = 4;
  localparam int PDWT_DAC_WINDOW = 3;
  localparam int PDWT_ENTRIES = 8;
  localparam int PDWT_LOCKABLE = 4;
  localparam int PDWT_PAGES = 4;
  localparam int PDWT_MASK_LO = 20;
  localparam int PDWT_PAGE_LO = 13;
  localparam int PDWT_TAG_LO = 15;
  localparam int PDWT_PTE_VALID = 0;
  localparam logic [2:0] PDWT_PTR_RESET = 3'h4;
  localparam logic [7:0] PDWT_RESET_FLAGS = 8'h00;
  typedef logic [16:0] pdwt_tag_t;
  typedef logic [19:0] pdwt_page_t;
  typedef enum {PDWT_IDLE, PDWT_FETCH, PDWT_WAIT, PDWT_DONE} pdwt_state_e;
endpackage

//--- rtl/pdwt_window_match.sv
`timescale 1ns/10ps
module pdwt_window_match
  import pdwt_pkg::*;
(
  // Incoming cycle
  input wire logic [63:0] pciAddr,
  input wire logic dualCycle,
  // Window setup
  input wire logic [11:0] baseHi,
  input wire logic [11:0] maskHi,
  input wire logic windowEnableBit,
  input wire logic dacCapable,
  input wire logic dacEnable,
  input wire logic [7:0] dacBase,
  // Result
  output logic hit
);
  // Only unmasked upper bits compare; all-ones mask compares nothing
  wire logic lowMatch = ((pciAddr[31:20] ^ baseHi) & ~maskHi) == 12'h000;
  wire logic highMatch = (pciAddr[63:40] == 24'h000000) && (pciAddr[39:32] == dacBase);
  wire logic dacOk = dacCapable && dacEnable && highMatch;
  // Whole window accepted, whatever the device really uses
  assign hit = windowEnableBit && lowMatch && (dualCycle ? dacOk : 1'b1);
endmodule

//--- rtl/pdwt_xlate_buffer.sv
`timescale 1ns/10ps
module pdwt_xlate_buffer
  import pdwt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Lookup
  input wire logic [18:0] lookAddr,
  input wire logic lookDual,
  output logic lookHit,
  output logic [19:0] lookPage,
  // Refill
  input wire logic fillEn,
  input wire logic [16:0] fillTag,
  input wire logic fillDual,
  input wire logic [3:0] fillValid,
  input wire logic [79:0] fillPages,
  // Control
  input wire logic [3:0] lockMask,
  input wire logic xlate_buffer_invalidate_all
);
  pdwt_tag_t tag [PDWT_ENTRIES];
  logic [PDWT_ENTRIES-1:0] dual;
  logic [PDWT_ENTRIES-1:0] used;
  logic [3:0] valid [PDWT_ENTRIES];
  pdwt_page_t page [PDWT_ENTRIES][PDWT_PAGES];
  logic [2:0] ptr;
  logic [PDWT_ENTRIES-1:0] hitVec;
  logic [19:0] pageSel [PDWT_ENTRIES];
  wire logic [1:0] sub = lookAddr[1:0];

  // Compare all tags in parallel; selected item must be valid
  genvar g;
  generate
    for (g = 0; g < PDWT_ENTRIES; g++) begin : gCmp
      assign hitVec[g] = used[g] && tag[g] == lookAddr[18:2] && dual[g] == lookDual && valid[g][sub];
      assign pageSel[g] = hitVec[g] ? page[g][sub] : 20'h00000;
    end
  endgenerate
  assign lookHit = |hitVec;

  always_comb begin
    lookPage = 20'h00000;
    for (int i = 0; i < PDWT_ENTRIES; i++) begin
      lookPage = lookPage | pageSel[i];
    end
  end

  // Entry is locked when it is one of the lockable four and its bit is set
  function automatic logic isLocked(input logic [2:0] idx, input logic [3:0] lk);
    isLocked = (idx < 3'(PDWT_LOCKABLE)) && lk[idx[1:0]];
  endfunction

  // Next unlocked slot after ptr; 4..7 never lock, so one always exists
  logic [2:0] next_ptr;
  always_comb begin
    logic [2:0] cand;
    logic found;
    cand = 3'h0;
    found = 1'b0;
    next_ptr = ptr;
    for (int k = 1; k <= PDWT_ENTRIES; k++) begin
      cand = ptr + 3'(k);
      if (!found && !isLocked(cand, lockMask)) begin
        next_ptr = cand;
        found = 1'b1;
      end
    end
  end
  wire logic [2:0] victim = isLocked(ptr, lockMask) ? next_ptr : ptr;

  // Refill writes victim; invalidate-all wins since its data may be stale
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      used <= PDWT_RESET_FLAGS;
      dual <= PDWT_RESET_FLAGS;
      ptr <= PDWT_PTR_RESET;
    end else if (xlate_buffer_invalidate_all) begin
      used <= PDWT_RESET_FLAGS;
    end else if (fillEn) begin
      used[victim] <= 1'b1;
      dual[victim] <= fillDual;
      ptr <= victim + 3'h1;
    end
  end

  // Data store has no reset; used guards it
  always_ff @(posedge clk) begin
    if (fillEn) begin
      tag[victim] <= fillTag;
      valid[victim] <= fillValid;
      for (int p = 0; p < PDWT_PAGES; p++) begin
        page[victim][p] <= fillPages[p*20 +: 20];
      end
    end
  end
endmodule

//--- rtl/pdwt_translator.sv
`timescale 1ns/10ps
module pdwt_translator
  import pdwt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // PCI request (one cycle strobe)
  input wire logic reqValid,
  input wire logic [63:0] reqAddr,
  input wire logic reqDual,
  output logic devsel,
  // Window setup, four windows packed
  input wire logic [47:0] winBase,
  input wire logic [47:0] winMask,
  input wire logic [3:0] window_enable_bit,
  input wire logic [3:0] table_map_select,
  input wire logic [83:0] winXlateBase,
  input wire logic winDacEnable,
  input wire logic [7:0] winDacBase,
  // Buffer control
  input wire logic [3:0] lockMask,
  input wire logic xlate_buffer_invalidate_all,
  // Page-table fetch to memory
  output logic pteReq,
  output logic [33:0] pteAddr,
  input wire logic pteAck,
  input wire logic [255:0] pteData,
  // Result
  output logic busy,
  output logic resValid,
  output logic [39:0] resAddr,
  output logic resFault
);
  pdwt_state_e state;
  logic [3:0] hits;
  logic [63:0] addr;
  logic dualQ;
  logic [1:0] winQ;

  genvar w;
  generate
    for (w = 0; w < PDWT_WINDOWS; w++) begin : gWin
      pdwt_window_match uMatch (
        .pciAddr(reqAddr),
        .dualCycle(reqDual),
        .baseHi(winBase[w*12 +: 12]),
        .maskHi(winMask[w*12 +: 12]),
        .windowEnableBit(window_enable_bit[w]),
        .dacCapable(w == PDWT_DAC_WINDOW),
        .dacEnable(winDacEnable),
        .dacBase(winDacBase),
        .hit(hits[w])
      );
    end
  endgenerate

  // Windows never overlap, so a plain encoder picks the hitter
  wire logic anyHit = |hits;
  wire logic [1:0] winNow = hits[3] ? 2'h3 : hits[2] ? 2'h2 : hits[1] ? 2'h1 : 2'h0;
  assign devsel = reqValid && !busy && anyHit;
  assign busy = (state != PDWT_IDLE);

  // Held request fields
  wire logic [11:0] mask = winMask[winQ*12 +: 12];
  wire logic [20:0] tbase = winXlateBase[winQ*21 +: 21];
  wire logic useTable = table_map_select[winQ];

  // Direct: AND-OR of base and offset, base bits under the mask are cleared
  wire logic [32:0] dirHi = {tbase[20:8] & ~{1'b0, mask}, 20'h00000};
  wire logic [32:0] dirLo = {1'b0, mask, 20'hfffff} & addr[32:0];
  wire logic [32:2] dirAddr = dirHi[32:2] | {1'b0, dirLo[31:2]};

  // Table address per entry, aligned to four-entry group
  // Base field holds bits 32..12; base bits that the offset covers are cleared
  function automatic logic [33:0] pteAt(input logic [20:0] tb, input logic [11:0] mk, input logic [31:0] a);
    logic [33:0] off;
    off = {12'h000, ({mk, 7'h7f} & a[31:13]), 3'h0};
    pteAt = ({1'b0, tb, 12'h000} & ~{12'h000, mk, 10'h000}) | off;
  endfunction
  wire logic [33:0] pteFull = pteAt(tbase, mask, addr[31:0]);
  wire logic [33:0] groupAddr = {pteFull[33:5], 5'h00};

  // Buffer lookup for the held address
  logic bufHit;
  logic [19:0] bufPage;
  logic fillEn;
  logic [3:0] fillValid;
  logic [79:0] fillPages;
  generate
    for (w = 0; w < PDWT_PAGES; w++) begin : gPte
      assign fillValid[w] = pteData[w*64 + PDWT_PTE_VALID];
      assign fillPages[w*20 +: 20] = pteData[w*64+1 +: 20];
    end
  endgenerate
  assign fillEn = (state == PDWT_WAIT) && pteAck;

  pdwt_xlate_buffer uBuf (
    .clk(clk),
    .rst_b(rst_b),
    .lookAddr(addr[31:13]),
    .lookDual(dualQ),
    .lookHit(bufHit),
    .lookPage(bufPage),
    .fillEn(fillEn),
    .fillTag(addr[31:15]),
    .fillDual(dualQ),
    .fillValid(fillValid),
    .fillPages(fillPages),
    .lockMask(lockMask),
    .xlate_buffer_invalidate_all(xlate_buffer_invalidate_all)
  );

  wire logic [1:0] sub = addr[14:13];
  wire logic fetchedValid = fillValid[sub];
  wire logic [19:0] fetchedPage = fillPages[sub*20 +: 20];

  // Capture request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr <= 64'h0000000000000000;
      dualQ <= 1'b0;
      winQ <= 2'h0;
    end else if (devsel) begin
      addr <= reqAddr;
      dualQ <= reqDual;
      winQ <= winNow;
    end
  end

  // Sequencer: hit -> translate, miss -> fetch group then translate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PDWT_IDLE;
      pteReq <= 1'b0;
      pteAddr <= 34'h000000000;
      resValid <= 1'b0;
      resAddr <= 40'h0000000000;
      resFault <= 1'b0;
    end else begin
      resValid <= 1'b0;
      resFault <= 1'b0;
      case (state)
        PDWT_IDLE: begin
          if (devsel) begin
            state <= PDWT_FETCH;
          end
        end
        PDWT_FETCH: begin
          if (!useTable) begin
            resValid <= 1'b1;
            resAddr <= {7'h00, dirAddr, 2'h0};
            state <= PDWT_IDLE;
          end else if (bufHit) begin
            resValid <= 1'b1;
            resAddr <= {7'h00, bufPage, addr[12:2], 2'h0};
            state <= PDWT_IDLE;
          end else begin
            pteReq <= 1'b1;
            pteAddr <= groupAddr;
            state <= PDWT_WAIT;
          end
        end
        PDWT_WAIT: begin
          if (pteAck) begin
            pteReq <= 1'b0;
            state <= PDWT_DONE;
            if (fetchedValid) begin
              resValid <= 1'b1;
              resAddr <= {7'h00, fetchedPage, addr[12:2], 2'h0};
            end else begin
              resFault <= 1'b1;
            end
          end
        end
        PDWT_DONE: begin
          state <= PDWT_IDLE;
        end
        default: begin
          state <= PDWT_IDLE;
        end
      endcase
    end
  end
endmodule

//--- tb/pdwt_sva.sv
`timescale 1ns/10ps
module pdwt_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request side
  input wire logic reqValid,
  input wire logic reqDual,
  input wire logic devsel,
  input wire logic [3:0] window_enable_bit,
  // Fetch and result
  input wire logic pteReq,
  input wire logic [33:0] pteAddr,
  input wire logic pteAck,
  input wire logic busy,
  input wire logic resValid,
  input wire logic [39:0] resAddr,
  input wire logic resFault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Steps of one transfer
  sequence s_take; devsel; endsequence
  sequence s_answer; busy ##1 (resValid ^ pteReq); endsequence
  sequence s_fetch; pteReq && !pteAck; endsequence
  property p_claim; devsel |-> reqValid && !busy; endproperty
  a_claim: assert property (p_claim) else $error("claim while busy or idle");
  property p_take; s_take |=> s_answer; endproperty
  a_take: assert property (p_take) else $error("no answer two cycles after take");
  property p_dac; devsel && reqDual |-> window_enable_bit[3]; endproperty
  a_dac: assert property (p_dac) else $error("dual cycle claimed without window three");
  property p_high; resValid |-> resAddr[39:33] == 7'h00; endproperty
  a_high: assert property (p_high) else $error("high address bits set");
  property p_hold; s_fetch |=> pteReq && $stable(pteAddr); endproperty
  a_hold: assert property (p_hold) else $error("fetch dropped before ack");
  property p_ack; pteReq && pteAck |=> (resValid ^ resFault) && !pteReq; endproperty
  a_ack: assert property (p_ack) else $error("no result after fetch");
  property p_fault; resFault |-> $past(pteAck); endproperty
  a_fault: assert property (p_fault) else $error("fault without fetch");
  property p_align; pteReq |-> pteAddr[4:0] == 5'h00; endproperty
  a_align: assert property (p_align) else $error("group address unaligned");
endmodule
bind pdwt_translator pdwt_sva i_pdwt_sva (.clk, .rst_b, .reqValid, .reqDual, .devsel, .window_enable_bit,
  .pteReq, .pteAddr, .pteAck, .busy, .resValid, .resAddr, .resFault);

//--- tb/pdwt_mem_model.sv
`timescale 1ns/10ps
module pdwt_mem_model (
  // Clock
  input wire logic clk,
  // Fetch port
  input wire logic pteReq,
  input wire logic [33:0] pteAddr,
  input wire logic slow,
  output logic pteAck,
  output logic [255:0] pteData
);
  int waitCnt = 0;
  logic [7:0] junk = 8'h00;
  // Table entry per quadword index; upper bits always zero
  function automatic logic [63:0] mkPte(input logic [30:0] q);
    return {43'h0, q[19:0] ^ 20'h5a5a5, ~q[6]};
  endfunction
  initial pteAck = 1'b0;
  // Answer once the wait count is reached; each output is assigned once per edge
  wire logic ackNow = pteReq && !pteAck && (waitCnt >= (slow ? 5 : 0));
  // Data lines churn when idle so stale data never stays the same
  always @(posedge clk) begin
    junk <= junk + 8'h3b;
    pteAck <= ackNow;
    waitCnt <= ackNow ? 0 : (pteReq && !pteAck) ? waitCnt + 1 : waitCnt;
    for (int i = 0; i < 4; i++) pteData[i*64+:64] <= ackNow ? mkPte({pteAddr[33:5], i[1:0]}) : {8{junk}};
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import pdwt_pkg::*;
  logic clk, rst_b, reqValid, reqDual, winDacEnable, xlate_buffer_invalidate_all, slow;
  logic devsel, pteReq, pteAck, busy, resValid, resFault;
  logic [63:0] reqAddr;
  logic [3:0] window_enable_bit, lockMask;
  logic [47:0] winBase = {12'h300, 12'h000, 12'h200, 12'h100};
  logic [47:0] winMask = 48'h000000000003;
  logic [3:0] table_map_select = 4'ha;
  logic [83:0] winXlateBase = {21'h000200, 21'h0, 21'h000100, 21'h000400};
  logic [7:0] winDacBase = 8'h12;
  logic [33:0] pteAddr;
  logic [255:0] pteData;
  logic [39:0] resAddr;
  logic [31:0] rnd = 32'h000168f2;
  logic [31:0] a;
  int errors = 0, cmp_count = 0, cyc = 0;
  pdwt_translator i_pdwt_translator (.clk, .rst_b, .reqValid, .reqAddr, .reqDual, .devsel, .winBase,
    .winMask, .window_enable_bit, .table_map_select, .winXlateBase, .winDacEnable, .winDacBase, .lockMask,
    .xlate_buffer_invalidate_all, .pteReq, .pteAddr, .pteAck, .pteData, .busy, .resValid, .resAddr, .resFault);
  pdwt_mem_model i_pdwt_mem_model (.clk, .pteReq, .pteAddr, .slow, .pteAck, .pteData);
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected results: window 0 direct 4 MB, table windows 1 MB
  function automatic logic [39:0] dirExp(input logic [31:0] a);
    return {7'h00, 33'h000400000 | {1'b0, a & 32'h003ffffc}};
  endfunction
  function automatic logic [39:0] tabExp(input logic [20:0] tb, input logic [31:0] a);
    logic [30:0] q;
    q = {1'b0, tb, 9'h000} | {24'h0, a[19:13]};
    return {7'h00, q[19:0] ^ 20'h5a5a5, a[12:2], 2'b00};
  endfunction
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One request; claim, fetch seen, fault and address checked
  task automatic acc(input logic [63:0] ad, input logic d, input logic eSel, input logic eMiss,
                     input logic eFlt, input logic [39:0] eAddr);
    logic sel, miss;
    int n;
    miss = 1'b0;
    n = 0;
    while (busy) @(negedge clk);
    @(posedge clk);
    #1 reqValid = 1'b1;
    reqAddr = ad;
    reqDual = d;
    #2 sel = devsel;
    @(posedge clk);
    #1 reqValid = 1'b0;
    chk(sel, eSel);
    while (sel && !(resValid || resFault) && n < 100) begin
      @(negedge clk);
      miss |= pteReq;
      n++;
    end
    if (sel) begin
      chk(resValid, !eFlt);
      chk(miss, eMiss);
      chk(resFault, eFlt);
      if (!eFlt) chk(resAddr, eAddr);
    end
  endtask
  task automatic tacc(input logic [3:0] pg, input logic eMiss);
    rnd = lfsr(rnd);
    a = 32'h20000000 | {pg, 15'h0} | (rnd & 32'h7ffc);
    acc({32'h0, a}, 1'b0, 1'b1, eMiss, 1'b0, tabExp(21'h000100, a));
  endtask
  task automatic inval;
    @(posedge clk);
    #1 xlate_buffer_invalidate_all = 1'b1;
    @(posedge clk);
    #1 xlate_buffer_invalidate_all = 1'b0;
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqAddr = 64'h0;
    reqDual = 1'b0;
    slow = 1'b0;
    window_enable_bit = 4'hb;
    winDacEnable = 1'b1;
    lockMask = 4'h0;
    xlate_buffer_invalidate_all = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    #1 chk({busy, resValid, resFault, pteReq, devsel}, 5'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a = 32'h10000000 | (rnd & 32'h003ffffc);
      acc({32'h0, a}, 1'b0, 1'b1, 1'b0, 1'b0, dirExp(a));
      acc({32'h0, rnd & 32'h000ffffc}, 1'b0, 1'b0, 1'b0, 1'b0, 40'h0);
      acc({32'h0, rnd | 32'h80000000}, 1'b0, 1'b0, 1'b0, 1'b0, 40'h0);
    end
    $display("test direct done");
    inval();
    for (int k = 0; k < 24; k++) begin
      @(posedge clk);
      #1 slow = k[0];
      if (k == 16) lockMask = 4'hf;
      tacc(k < 16 ? k[2:0] : k < 20 ? k - 8 : k - 16, k < 8 || (k >= 16 && k < 20));
    end
    inval();
    lockMask = 4'h0;
    tacc(4'h4, 1'b1);
    acc({32'h0, 32'h20080000}, 1'b0, 1'b1, 1'b1, 1'b1, 40'h0);
    acc({32'h0, 32'h20080000}, 1'b0, 1'b1, 1'b1, 1'b1, 40'h0);
    $display("test table done");
    a = 32'h30000000 | (rnd & 32'h0007fffc);
    acc({32'h12, a}, 1'b1, 1'b1, 1'b1, 1'b0, tabExp(21'h000200, a));
    acc({32'h12, a}, 1'b1, 1'b1, 1'b0, 1'b0, tabExp(21'h000200, a));
    acc({32'h0, a}, 1'b0, 1'b1, 1'b1, 1'b0, tabExp(21'h000200, a));
    acc({32'h13, a}, 1'b1, 1'b0, 1'b0, 1'b0, 40'h0);
    acc({32'h112, a}, 1'b1, 1'b0, 1'b0, 1'b0, 40'h0);
    acc({32'h12, 32'h10000000}, 1'b1, 1'b0, 1'b0, 1'b0, 40'h0);
    @(posedge clk);
    #1 winDacEnable = 1'b0;
    acc({32'h12, a}, 1'b1, 1'b0, 1'b0, 1'b0, 40'h0);
    $display("test dual done");
    give_verdict();
  end
endmodule
